// ---- sap_map.svh ----
// constants and bit positions for the converter host port
// Function
// - standby input high holds standby power state
// - nap input high holds reduced-power nap state
// - select and read low drive output register
// - offset write needs select low with write
// - offset captured at write strobe falling edge
// - start falling edge drives busy low throughout
// - first mode raises busy after result latched
// - second mode raises busy before result latched
// - second mode latches result at next start
// - twelve data lines, line eleven is msb
// - data drivers governed by select, read, write
// - start falling edge holds sample, begins conversion
// - low reset aborts conversion, clears offset register
// - thirteenth output line carries overrange bit
// - saturate enable clips overrange results to ones, clearing overrange only for sums up to 8191; negative sums clip to zero always
`ifndef SAP_MAP_SVH
`define SAP_MAP_SVH
`define SAP_DATA_W        12
`define SAP_RAW_W         13
`define SAP_FIFO_DEPTH    4
`define SAP_CLK_PERIOD_NS 25
`define SAP_CONV_TIME_NS  300
`define SAP_CONV_CYCLES   ((`SAP_CONV_TIME_NS) / (`SAP_CLK_PERIOD_NS))
`define SAP_OFFSET_RST    12'h000
`define SAP_RESULT_RST    13'h0000
`define SAP_FULL_SCALE    12'hfff
`define SAP_PIN_W         21
`define SAP_PIN_RST       21'h1e_0000
`define SAP_PIN_TRIG      20
`define SAP_PIN_CS        19
`define SAP_PIN_RD        18
`define SAP_PIN_RSTN      17
`define SAP_PIN_WR        16
`define SAP_PIN_DEEP_SLEEP_REQUEST      15
`define SAP_PIN_NAP       14
`define SAP_PIN_MODE_HI   13
`define SAP_PIN_SAT       12
`endif

// ---- sap_pkg.sv ----
// types shared by the converter host port
package sap_pkg;
  typedef struct packed {
    logic        ovr;
    logic [11:0] code;
  } sap_word_t;
  typedef enum logic [1:0] {
    SAP_PWR_NORMAL,
    SAP_PWR_NAP,
    SAP_PWR_STANDBY
  } sap_pwr_t;
endpackage : sap_pkg

// ---- sap_port.sv ----
// converter host port: pin filters, conversion timing, result fifo
`include "sap_map.svh"

module sap_fifo
  import sap_pkg::*;
#(
  parameter int WIDTH = 13,
  parameter int DEPTH = `SAP_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             flush_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("sap_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;
  assign in_ready_o  = (wr_q - rd_q) != (AW + 1)'(DEPTH);
  assign out_valid_o = wr_q != rd_q;
  assign out_data_o  = mem_q[rd_q[AW-1:0]];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (flush_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end
endmodule : sap_fifo

module sap_port
  import sap_pkg::*;
#(
  parameter int CONV_CYCLES = `SAP_CONV_CYCLES
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  // host control pins
  input  wire logic        sample_trigger_n_i,
  input  wire logic        reset_pin_n_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        read_strobe_n_i,
  input  wire logic        write_strobe_i,
  input  wire logic        deep_sleep_request_i,
  input  wire logic        nap_request_i,
  input  wire logic        timing_select_low_i,
  input  wire logic        timing_select_high_i,
  input  wire logic        saturate_enable_i,
  // data lines, split three ways
  input  wire logic [11:0] data_lines_i,
  output logic      [11:0] data_lines_o,
  output logic             data_lines_oe_o,
  output logic             overrange_bit_o,
  output logic             overrange_bit_oe_o,
  // status
  output logic             busy_o,
  // analog core side
  input  wire logic [12:0] raw_code_i,
  output logic             hold_o,
  output sap_pwr_t         power_state_o
);
  initial begin
    if (CONV_CYCLES < 1) $error("sap_port conversion cycles below one");
  end

  typedef enum logic [1:0] {S_IDLE, S_CONV, S_PUSH, S_LATCH} sap_state_t;

  // three-stage pin filter; a level counts once stages two and three agree
  logic [`SAP_PIN_W-1:0] pin_raw;
  logic [`SAP_PIN_W-1:0] s1_q, s2_q, s3_q, pin_q;
  assign pin_raw = {sample_trigger_n_i, chip_select_n_i, read_strobe_n_i,
                    reset_pin_n_i, write_strobe_i, deep_sleep_request_i,
                    nap_request_i, timing_select_high_i, saturate_enable_i,
                    data_lines_i};
  // reset image equals the idle pins, so no false edge follows reset
  localparam logic [`SAP_PIN_W-1:0] PIN_RST = `SAP_PIN_RST;
  for (genvar i = 0; i < `SAP_PIN_W; i++) begin : g_pin
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        s1_q[i]  <= PIN_RST[i];
        s2_q[i]  <= PIN_RST[i];
        s3_q[i]  <= PIN_RST[i];
        pin_q[i] <= PIN_RST[i];
      end else begin
        s1_q[i] <= pin_raw[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) pin_q[i] <= s3_q[i];
      end
    end
  end

  logic trig_n, cs_n, rd_n, rst_n, wr, deep_sleep_request, nap, timing_select_high, sat;
  assign trig_n = pin_q[`SAP_PIN_TRIG];
  assign cs_n   = pin_q[`SAP_PIN_CS];
  assign rd_n   = pin_q[`SAP_PIN_RD];
  assign rst_n  = pin_q[`SAP_PIN_RSTN];
  assign wr     = pin_q[`SAP_PIN_WR];
  assign deep_sleep_request   = pin_q[`SAP_PIN_DEEP_SLEEP_REQUEST];
  assign nap    = pin_q[`SAP_PIN_NAP];
  assign timing_select_high  = pin_q[`SAP_PIN_MODE_HI];
  assign sat    = pin_q[`SAP_PIN_SAT];

  // edge history of filtered strobes
  logic trig_n_q, wr_q;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      trig_n_q <= 1'b1;
      wr_q     <= 1'b0;
    end else begin
      trig_n_q <= trig_n;
      wr_q     <= wr;
    end
  end
  logic trig_fall, wr_fall;
  assign trig_fall = trig_n_q & ~trig_n & rst_n;
  assign wr_fall   = wr_q & ~wr & rst_n;

  // power state; standby outranks nap
  sap_pwr_t pwr_q;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)  pwr_q <= SAP_PWR_NORMAL;
    else if (deep_sleep_request)  pwr_q <= SAP_PWR_STANDBY;
    else if (nap)   pwr_q <= SAP_PWR_NAP;
    else            pwr_q <= SAP_PWR_NORMAL;
  end
  assign power_state_o = pwr_q;

  // offset register: word is the one the host held while write was high
  logic [11:0] wr_data_q;
  logic [11:0] offset_q;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_data_q <= `SAP_OFFSET_RST;
      offset_q  <= `SAP_OFFSET_RST;
    end else begin
      if (wr) wr_data_q <= pin_q[11:0];
      if (!rst_n) offset_q <= `SAP_OFFSET_RST;
      else if (wr_fall && !cs_n) offset_q <= wr_data_q;
    end
  end

  // offset is two's complement; clipping folds overrange away unless the sum passes 8191
  sap_word_t   result;
  logic [12:0] held_q;
  logic signed [14:0] sum;
  always_comb begin
    sum    = $signed({2'b00, held_q}) + $signed({{3{offset_q[11]}}, offset_q});
    result = sap_word_t'(sum[12:0]);
    if (sum < 0) result = `SAP_RESULT_RST;
    else if (sum > 15'sd8191) result = {1'b1, `SAP_FULL_SCALE};
    else if (sat && sum[12]) result = {1'b0, `SAP_FULL_SCALE};
  end

  // conversion sequencer
  sap_state_t  state_q;
  logic [$clog2(CONV_CYCLES+1)-1:0] cnt_q;
  logic        fifo_in_ready, fifo_out_valid, fifo_pop;
  sap_word_t   fifo_out;
  logic        start;
  assign start = trig_fall && state_q == S_IDLE && pwr_q == SAP_PWR_NORMAL;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= S_IDLE;
      cnt_q   <= '0;
      held_q  <= '0;
    end else if (!rst_n || pwr_q == SAP_PWR_STANDBY) begin
      state_q <= S_IDLE;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (start) begin
            held_q  <= raw_code_i;
            cnt_q   <= '0;
            state_q <= S_CONV;
          end
        end
        S_CONV: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == ($bits(cnt_q))'(CONV_CYCLES - 1)) state_q <= S_PUSH;
        end
        S_PUSH: begin
          // a full fifo stalls completion; busy stays low meanwhile
          if (fifo_in_ready) state_q <= timing_select_high ? S_IDLE : S_LATCH;
        end
        S_LATCH: begin
          if (!fifo_out_valid) state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
  assign busy_o = state_q == S_IDLE;
  assign hold_o = state_q == S_CONV;

  // first mode drains at once, second waits for the next start edge
  assign fifo_pop = fifo_out_valid && rst_n &&
                    (timing_select_high ? trig_fall : 1'b1);

  sap_fifo #(
    .WIDTH ($bits(sap_word_t)),
    .DEPTH (`SAP_FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .sys_rst_i   (sys_rst_i),
    .flush_i     (!rst_n),
    .in_valid_i  (state_q == S_PUSH),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (result),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out)
  );

  // output register and drivers
  sap_word_t out_q;
  logic      oe_q;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_q <= `SAP_RESULT_RST;
      oe_q  <= 1'b0;
    end else begin
      if (fifo_pop) out_q <= fifo_out;
      oe_q <= !cs_n && !rd_n && !wr;
    end
  end
  assign data_lines_o       = out_q.code;
  assign data_lines_oe_o    = oe_q;
  assign overrange_bit_o    = out_q.ovr;
  assign overrange_bit_oe_o = oe_q;

  // checker helper: counts the hold window on its own, apart from cnt_q
  logic [$bits(cnt_q):0] hold_len_q;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)   hold_len_q <= '0;
    else if (hold_o) hold_len_q <= hold_len_q + 1'b1;
    else             hold_len_q <= '0;
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  busy_fall_start_a: assert property (start |=> !busy_o [*2])
    else $error("busy did not fall after start");
  conv_length_a: assert property (
      $fell(hold_o) && state_q == S_PUSH
      |-> hold_len_q == ($bits(hold_len_q))'(CONV_CYCLES))
    else $error("conversion length differs from count");
  timing_select_low_latch_a: assert property (
      !timing_select_high && $rose(busy_o) && rst_n |-> !fifo_out_valid)
    else $error("busy rose before result latched");
  timing_select_high_busy_a: assert property (
      timing_select_high && state_q == S_PUSH && fifo_in_ready && rst_n
      && pwr_q != SAP_PWR_STANDBY |=> busy_o)
    else $error("busy not raised at completion");
  timing_select_high_hold_a: assert property (
      timing_select_high && !trig_fall |=> $stable(out_q))
    else $error("result latched without start edge");
  read_drive_a: assert property (
      !cs_n && !rd_n && !wr |=> data_lines_oe_o)
    else $error("bus not driven during read");
  idle_hiz_a: assert property (
      cs_n || rd_n |=> !data_lines_oe_o)
    else $error("bus driven while idle");
  offset_write_a: assert property (
      wr_fall && !cs_n |=> offset_q == $past(wr_data_q))
    else $error("offset not captured on write fall");
  offset_clear_a: assert property (
      !rst_n |=> offset_q == `SAP_OFFSET_RST)
    else $error("offset not cleared by reset pin");
  pin_abort_a: assert property (!rst_n |=> busy_o)
    else $error("reset pin did not abort conversion");
  saturate_enable_ovr_a: assert property (
      sat && state_q == S_PUSH |-> !result.ovr)
    else $error("overrange set while clipping");
  // an idle sequencer must not leave idle in nap or standby
  standby_block_a: assert property (
      pwr_q != SAP_PWR_NORMAL && busy_o |=> busy_o)
    else $error("conversion started in low power");
endmodule : sap_port

// ---- sap_host_bus.sv ----
// host-side model of the shared data lines
module sap_host_bus (
  // clock
  input  wire logic        clk_i,
  // device drivers
  input  wire logic [11:0] dev_d_i,
  input  wire logic        dev_oe_i,
  // host drivers
  input  wire logic [11:0] host_d_i,
  input  wire logic        host_oe_i,
  // resolved wire
  output logic      [11:0] bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // known start value, so released lines really toggle
  logic [11:0] last_q = 12'h000;
  always @(posedge clk_i) begin
    last_q <= bus_o;
  end
  // floating lines toggle so a stale value never passes for data
  always_comb begin
    if (dev_oe_i) begin
      bus_o = dev_d_i;
    end else if (host_oe_i) begin
      bus_o = host_d_i;
    end else begin
      bus_o = ~last_q;
    end
  end
endmodule : sap_host_bus

// ---- sap_port_bench.sv ----
// self-checking bench for the converter host port
module sap_port_bench;
  import sap_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, trig_n, rpin_n, cs_n, rd_n, wr;
  logic        deep_sleep_request, nap, tsel_hi, sat, host_oe, cs_idle;
  logic [11:0] host_d, bus, dev_d;
  logic [12:0] raw;
  logic        dev_oe, ovr, busy, ovr_oe, hold;
  sap_pwr_t    pwr;
  int          n_errors, comparisons, cyc;

  sap_port u_sap_port (
    .core_clk_i(clk), .sys_rst_i(rst), .sample_trigger_n_i(trig_n),
    .reset_pin_n_i(rpin_n), .chip_select_n_i(cs_n),
    .read_strobe_n_i(rd_n), .write_strobe_i(wr),
    .deep_sleep_request_i(deep_sleep_request), .nap_request_i(nap),
    .timing_select_low_i(~tsel_hi), .timing_select_high_i(tsel_hi),
    .saturate_enable_i(sat), .data_lines_i(bus), .data_lines_o(dev_d),
    .data_lines_oe_o(dev_oe), .overrange_bit_o(ovr),
    .overrange_bit_oe_o(ovr_oe), .busy_o(busy), .raw_code_i(raw),
    .hold_o(hold), .power_state_o(pwr));
  sap_host_bus u_sap_host_bus (
    .clk_i(clk), .dev_d_i(dev_d), .dev_oe_i(dev_oe),
    .host_d_i(host_d), .host_oe_i(host_oe), .bus_o(bus));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic check(input string nm, input logic [12:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic stop_test;
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // host write: word first, then a strobe of several clocks
  task automatic write_off(input logic sel_n, input logic [11:0] v);
    cs_n <= sel_n;
    host_d <= v;
    host_oe <= 1'b1;
    tick(6);
    wr <= 1'b1;
    tick(6);
    wr <= 1'b0;
    tick(6);
    cs_n <= cs_idle;
    host_oe <= 1'b0;
    tick(6);
  endtask : write_off

  // start, watch busy low, then wait for it to return
  task automatic convert(input logic [12:0] r);
    int k;
    raw <= r;
    trig_n <= 1'b0;
    tick(6);
    check("busy_start", 13'h0000, {12'h000, busy});
    check("hold_conv", 13'h0001, {12'h000, hold});
    trig_n <= 1'b1;
    tick(6);
    check("busy_mid", 13'h0000, {12'h000, busy});
    for (k = 0; k < 60 && busy !== 1'b1; k++) tick(1);
    check("busy_end", 13'h0001, {12'h000, busy});
    check("hold_end", 13'h0000, {12'h000, hold});
  endtask : convert

  task automatic read(input logic [12:0] exp);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    tick(6);
    check("read_oe", 13'h0001, {12'h000, dev_oe});
    check("read_data", exp, {ovr, bus});
    check("read_ovr_oe", 13'h0001, {12'h000, ovr_oe});
    rd_n <= 1'b1;
    cs_n <= cs_idle;
    tick(6);
    check("idle_oe", 13'h0000, {12'h000, dev_oe});
    check("idle_ovr_oe", 13'h0000, {12'h000, ovr_oe});
  endtask : read

  // hang guard; the run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    int i;
    {rst, trig_n, rpin_n, cs_n, rd_n, cs_idle} = 6'b11_1111;
    {wr, deep_sleep_request, nap, tsel_hi, sat, host_oe} = 6'b00_0000;
    host_d = 12'h000;
    raw = 13'h0000;
    tick(2);
    rst <= 1'b0;
    tick(6);
    check("rst_busy", 13'h0001, {12'h000, busy});
    check("rst_oe", 13'h0000, {12'h000, dev_oe});
    convert(13'h0123);
    read(13'h0123);
    write_off(1'b1, 12'h010);
    convert(13'h0123);
    read(13'h0123);
    write_off(1'b0, 12'h010);
    convert(13'h0123);
    read(13'h0133);
    rpin_n <= 1'b0;
    tick(6);
    rpin_n <= 1'b1;
    tick(6);
    convert(13'h0123);
    read(13'h0123);
    convert(13'h1f00);
    read(13'h1f00);
    sat <= 1'b1;
    convert(13'h1f00);
    read(13'h0fff);
    sat <= 1'b0;
    cs_idle <= 1'b0;
    cs_n <= 1'b0;
    tsel_hi <= 1'b1;
    tick(6);
    convert(13'h0456);
    read(13'h0fff);
    convert(13'h0789);
    read(13'h0456);
    cs_idle <= 1'b1;
    cs_n <= 1'b1;
    for (i = 0; i < 2; i++) begin
      nap <= (i == 0);
      deep_sleep_request <= (i == 1);
      tick(6);
      check("pwr", (i == 0) ? 13'h0001 : 13'h0002, {11'h000, pwr});
      trig_n <= 1'b0;
      tick(6);
      check("busy_refused", 13'h0001, {12'h000, busy});
      trig_n <= 1'b1;
      nap <= 1'b0;
      deep_sleep_request <= 1'b0;
      tick(6);
      check("pwr_back", 13'h0000, {11'h000, pwr});
    end
    stop_test();
  end
endmodule : sap_port_bench
